// File: hdl/mrb_pkg.sv
// Package for the memory-mapped register builder.
// Assumes a single clock domain and a word-aligned byte address bus.
package mrb_pkg;
   // Word addresses of each mapped item
   localparam int MRB_ADDR_CTRL = 0;    // Read-write register plus continuous tap
   localparam int MRB_ADDR_WO = 1;      // Write-only register
   localparam int MRB_ADDR_DRIVE = 2;   // Driven output and driven-with-readback
   localparam int MRB_ADDR_FLOW = 3;    // Valid-only output channel
   localparam int MRB_ADDR_STREAM = 4;  // Non-blocking stream read
   localparam int MRB_ADDR_STICKY = 5;  // Sticky accumulator
   localparam int MRB_ADDR_WIDE_RD = 6; // Wide read, base word
   localparam int MRB_ADDR_WIDE_WR = 8; // Wide write, base word
   // Field bit positions
   localparam int MRB_POS_CTRL = 0;
   localparam int MRB_POS_TAP = 8;
   localparam int MRB_POS_WO = 4;
   localparam int MRB_POS_DRV = 0;
   localparam int MRB_POS_DRV_RB = 16;
   localparam int MRB_POS_FLOW = 0;
   localparam int MRB_POS_SVALID = 31;
   localparam int MRB_POS_SPAYLOAD = 0;
   localparam int MRB_POS_STICKY = 0;
   // Field widths
   localparam int MRB_W_CTRL = 8;
   localparam int MRB_W_TAP = 8;
   localparam int MRB_W_WO = 12;
   localparam int MRB_W_DRV = 8;
   localparam int MRB_W_DRV_RB = 8;
   localparam int MRB_W_FLOW = 16;
   localparam int MRB_W_SPAYLOAD = 16;
   localparam int MRB_W_STICKY = 8;
   localparam int MRB_W_WIDE = 48;
   // Access kind held by the shared decoder
   typedef enum logic [1:0] {MRB_ACC_IDLE, MRB_ACC_READ, MRB_ACC_WRITE} mrb_acc_e;
endpackage : mrb_pkg

// File: hdl/mrb_decode.sv
// Address decoder for the register builder: one read and one write hit line per word.
// Assumes byte addresses aligned to the bus word.
`timescale 1ns/10ps
module mrb_decode
   import mrb_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int WORD_W = 32,
   parameter int N_WORDS = 10
)
(
   // Bus request
   input wire logic [ADDR_W-1:0] bus_addr,
   input wire logic bus_rd,
   input wire logic bus_wr,
   // Per-word strobes
   output logic [N_WORDS-1:0] rd_hit,
   output logic [N_WORDS-1:0] wr_hit,
   output mrb_acc_e acc_kind
);
   localparam int LSB = $clog2(WORD_W / 8);

   // One address compare per word for each strobe; every hook at an address shares its strobe
   genvar gi;
   generate
      for (gi = 0; gi < N_WORDS; gi++)
      begin : g_hit
         assign rd_hit[gi] = bus_rd && (bus_addr[ADDR_W-1:LSB] == (ADDR_W - LSB)'(gi));
         assign wr_hit[gi] = bus_wr && (bus_addr[ADDR_W-1:LSB] == (ADDR_W - LSB)'(gi));
      end
   endgenerate

   // Access kind, read taking precedence if both strobes rise together
   always_comb
   begin
      if (bus_rd)
         acc_kind = MRB_ACC_READ;
      else if (bus_wr)
         acc_kind = MRB_ACC_WRITE;
      else
         acc_kind = MRB_ACC_IDLE;
   end
endmodule : mrb_decode

// File: hdl/mrb_register_builder.sv
// Memory-mapped register builder: a fixed example map behind a simple
// read/write strobe bus. Assumes a master that pulses read or write for one
// cycle per transaction with word-aligned byte addresses.
`timescale 1ns/10ps
module mrb_register_builder
   import mrb_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int WORD_W = 32
)
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Bus side
   input wire logic [ADDR_W-1:0] bus_addr,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic [WORD_W-1:0] bus_wdata,
   output logic [WORD_W-1:0] bus_rdata,
   output logic bus_rvalid,
   // Register outputs
   output logic [MRB_W_CTRL-1:0] ctrl_r,
   output logic [MRB_W_WO-1:0] wo_r,
   output logic [MRB_W_DRV-1:0] drv_out,
   output logic [MRB_W_DRV_RB-1:0] drv_rb_out,
   output logic [MRB_W_WIDE-1:0] wide_wr_r,
   // Continuous tap
   output logic [MRB_W_TAP-1:0] tap_out,
   // Valid-only channel
   output logic flow_valid,
   output logic [MRB_W_FLOW-1:0] flow_payload,
   // Stream consumed by reads
   input wire logic strm_valid,
   input wire logic [MRB_W_SPAYLOAD-1:0] strm_payload,
   output logic strm_ready,
   // Sticky event inputs
   input wire logic [MRB_W_STICKY-1:0] sticky_in,
   // Wide status read in pieces
   input wire logic [MRB_W_WIDE-1:0] wide_rd_in,
   // Write and read event pulses
   output logic ctrl_wr_pulse,
   output logic sticky_rd_pulse
);
   // Words taken by the wide items, and the count of decoded words
   localparam int WIDE_WORDS = (MRB_W_WIDE - 1) / WORD_W + 1;
   localparam int N_WORDS = MRB_ADDR_WIDE_WR + WIDE_WORDS;

   // Elaboration checks: a map that cannot fit is refused, never truncated
   // End bit of each field; all must fit inside one bus word
   localparam int N_FIELDS = 9;
   localparam int FIELD_END [N_FIELDS] = '{
      MRB_POS_CTRL + MRB_W_CTRL,
      MRB_POS_TAP + MRB_W_TAP,
      MRB_POS_WO + MRB_W_WO,
      MRB_POS_DRV + MRB_W_DRV,
      MRB_POS_DRV_RB + MRB_W_DRV_RB,
      MRB_POS_FLOW + MRB_W_FLOW,
      MRB_POS_SVALID + 1,
      MRB_POS_SPAYLOAD + MRB_W_SPAYLOAD,
      MRB_POS_STICKY + MRB_W_STICKY
   };

   // Word addresses of the single-word items
   localparam int N_ITEMS = 6;
   localparam int ITEM_ADDR [N_ITEMS] = '{
      MRB_ADDR_CTRL,
      MRB_ADDR_WO,
      MRB_ADDR_DRIVE,
      MRB_ADDR_FLOW,
      MRB_ADDR_STREAM,
      MRB_ADDR_STICKY
   };

   // Refuse a field that runs past the bus word
   genvar fi;
   generate
      for (fi = 0; fi < N_FIELDS; fi++)
      begin : g_fit
         if (FIELD_END[fi] > WORD_W)
         begin : g_overrun
            $error("mapped field runs past the bus word");
         end
      end
   endgenerate

   // Refuse items that collide; a shared word would mix unrelated reads
   genvar ai, aj;
   generate
      for (ai = 0; ai < N_ITEMS; ai++)
      begin : g_addr_a
         if (ITEM_ADDR[ai] >= MRB_ADDR_WIDE_RD)
         begin : g_into_wide
            $error("single-word item sits among the wide words");
         end
         for (aj = ai + 1; aj < N_ITEMS; aj++)
         begin : g_addr_b
            if (ITEM_ADDR[ai] == ITEM_ADDR[aj])
            begin : g_clash
               $error("two single-word items share one address");
            end
         end
      end
   endgenerate

   // Refuse bus shapes the decoder cannot serve and overlapping wide words or fields; lanes are dropped by slicing
   generate
      if (WORD_W < 8 || (WORD_W & (WORD_W - 1)) != 0)
      begin : g_bad_word
         $error("bus word must be a power of two bytes");
      end
      if (ADDR_W < $clog2(N_WORDS) + $clog2(WORD_W / 8))
      begin : g_bad_addr
         $error("address width too small for the map");
      end
      if (MRB_ADDR_WIDE_RD + WIDE_WORDS > MRB_ADDR_WIDE_WR)
      begin : g_wide_overlap
         $error("wide read words run into the wide write words");
      end
      if (MRB_POS_DRV + MRB_W_DRV > MRB_POS_DRV_RB)
      begin : g_drv_overlap
         $error("the two driven fields overlap in their word");
      end
      if (MRB_POS_SVALID < MRB_POS_SPAYLOAD + MRB_W_SPAYLOAD)
      begin : g_strm_overlap
         $error("stream flag must sit above its payload");
      end
   endgenerate

   // Decode strobes, internal state and the read word being built
   logic [N_WORDS-1:0] rd_hit;
   logic [N_WORDS-1:0] wr_hit;
   mrb_acc_e acc_kind;
   logic [MRB_W_STICKY-1:0] sticky_r;
   logic [WIDE_WORDS*WORD_W-1:0] wide_rd_ext;
   logic [WORD_W-1:0] rdata_nxt;

   // Shared decode: every item at an address hangs off one strobe
   // Read wins the decoder's kind; both strobes still act on their items
   mrb_decode #(
      .ADDR_W(ADDR_W),
      .WORD_W(WORD_W),
      .N_WORDS(N_WORDS)
   ) u_decode (
      .bus_addr(bus_addr),
      .bus_rd(bus_rd),
      .bus_wr(bus_wr),
      .rd_hit(rd_hit),
      .wr_hit(wr_hit),
      .acc_kind(acc_kind)
   );

   // Wide input padded to whole words; spare bits read as zero
   assign wide_rd_ext = (WIDE_WORDS * WORD_W)'(wide_rd_in);

   // Hook strobes, one per hooked address; each acts in its access cycle
   // Registered marks follow one cycle later; strm_ready alone is driven straight from its strobe
   logic ctrl_wr_hook;
   logic flow_wr_hook;
   logic strm_rd_hook;
   logic sticky_rd_hook;
   assign ctrl_wr_hook = wr_hit[MRB_ADDR_CTRL];
   assign flow_wr_hook = wr_hit[MRB_ADDR_FLOW];
   assign strm_rd_hook = rd_hit[MRB_ADDR_STREAM];
   assign sticky_rd_hook = rd_hit[MRB_ADDR_STICKY];

   // Read-write control register
   // Read back at the same position it is written from
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         ctrl_r <= '0;
      else if (wr_hit[MRB_ADDR_CTRL])
         ctrl_r <= bus_wdata[MRB_POS_CTRL +: MRB_W_CTRL];
   end

   // Write hook on the control address
   // Registered, so the mark trails the write by one cycle
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         ctrl_wr_pulse <= 1'b0;
      else
         ctrl_wr_pulse <= ctrl_wr_hook;
   end

   // Tap follows write data regardless of address or strobe
   // One cycle late, the price of an output straight from a flop
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         tap_out <= '0;
      else
         tap_out <= bus_wdata[MRB_POS_TAP +: MRB_W_TAP];
   end

   // Write-only register; no read path exists for it
   // Reads of its word return zero, so software cannot check it
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         wo_r <= '0;
      else if (wr_hit[MRB_ADDR_WO])
         wo_r <= bus_wdata[MRB_POS_WO +: MRB_W_WO];
   end

   // Driven output, held between writes
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         drv_out <= '0;
      else if (wr_hit[MRB_ADDR_DRIVE])
         drv_out <= bus_wdata[MRB_POS_DRV +: MRB_W_DRV];
   end

   // Driven output with read-back, sharing the word with the one above
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         drv_rb_out <= '0;
      else if (wr_hit[MRB_ADDR_DRIVE])
         drv_rb_out <= bus_wdata[MRB_POS_DRV_RB +: MRB_W_DRV_RB];
   end

   // Valid-only channel: registered so outputs come from flops, one cycle late
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         flow_valid <= 1'b0;
      else
         flow_valid <= flow_wr_hook;
   end

   // Flow payload taps the write data every cycle, lined up with its valid
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         flow_payload <= '0;
      else
         flow_payload <= bus_wdata[MRB_POS_FLOW +: MRB_W_FLOW];
   end

   // Stream ready is the one output not from a flop: a registered ready
   // would consume one cycle after the read and drop or repeat an item
   assign strm_ready = strm_rd_hook;

   // Sticky accumulator; a read keeps only this cycle's inputs
   // A read and a new event together: the event survives the clear
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         sticky_r <= '0;
      else if (sticky_rd_hook)
         sticky_r <= sticky_in;
      else
         sticky_r <= sticky_r | sticky_in;
   end

   // Read hook pulse for the sticky address
   // Tells user logic that the accumulated bits were handed over
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         sticky_rd_pulse <= 1'b0;
      else
         sticky_rd_pulse <= sticky_rd_hook;
   end

   // Wide write: each word address loads its own slice
   // Not atomic: between the word writes the halves belong to different values
   genvar wi;
   generate
      for (wi = 0; wi < WIDE_WORDS; wi++)
      begin : g_wide_wr
         // Slice bounds; the top word may be only partly used
         localparam int LO = wi * WORD_W;
         localparam int NB = (MRB_W_WIDE - LO < WORD_W) ? MRB_W_WIDE - LO : WORD_W;
         always_ff @(posedge sys_clk or negedge arst_n)
         begin
            if (!arst_n)
               wide_wr_r[LO +: NB] <= '0;
            else if (wr_hit[MRB_ADDR_WIDE_WR + wi])
               wide_wr_r[LO +: NB] <= bus_wdata[NB-1:0];
         end
      end
   endgenerate

   // Read mux; bits no mapping claims stay zero
   // A read and a write in one cycle both act; the read sees the old value
   always_comb
   begin
      rdata_nxt = '0;
      if (rd_hit[MRB_ADDR_CTRL])
         rdata_nxt[MRB_POS_CTRL +: MRB_W_CTRL] = ctrl_r;
      if (rd_hit[MRB_ADDR_DRIVE])
         rdata_nxt[MRB_POS_DRV_RB +: MRB_W_DRV_RB] = drv_rb_out;
      if (rd_hit[MRB_ADDR_STREAM])
      begin
         rdata_nxt[MRB_POS_SVALID] = strm_valid;
         rdata_nxt[MRB_POS_SPAYLOAD +: MRB_W_SPAYLOAD] = strm_payload;
      end
      if (rd_hit[MRB_ADDR_STICKY])
         rdata_nxt[MRB_POS_STICKY +: MRB_W_STICKY] = sticky_r;
      for (int k = 0; k < WIDE_WORDS; k++)
      begin
         if (rd_hit[MRB_ADDR_WIDE_RD + k])
            rdata_nxt = wide_rd_ext[k * WORD_W +: WORD_W];
      end
   end

   // Read response one cycle after the request
   // The data word reloads every cycle and is zero when no read is answered
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bus_rdata <= '0;
         bus_rvalid <= 1'b0;
      end
      else
      begin
         bus_rvalid <= (acc_kind == MRB_ACC_READ);
         bus_rdata <= rdata_nxt;
      end
   end
endmodule : mrb_register_builder

// File: verification/mrb_register_builder_asserts.sv
// Checker for the register builder's bus and output timing.
// Assumes one clock and the word-aligned map of mrb_pkg.
`timescale 1ns/10ps
module mrb_register_builder_asserts
   import mrb_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int WORD_W = 32
)
(
   // Clock, reset and bus
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [ADDR_W-1:0] bus_addr,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic [WORD_W-1:0] bus_wdata,
   input wire logic [WORD_W-1:0] bus_rdata,
   input wire logic bus_rvalid,
   // Observed outputs
   input wire logic [MRB_W_CTRL-1:0] ctrl_r,
   input wire logic [MRB_W_DRV-1:0] drv_out,
   input wire logic [MRB_W_TAP-1:0] tap_out,
   input wire logic flow_valid,
   input wire logic strm_ready,
   input wire logic ctrl_wr_pulse,
   input wire logic sticky_rd_pulse
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   localparam int LSB = $clog2(WORD_W / 8);
   logic [ADDR_W-LSB-1:0] wa;
   // Word index, byte lanes dropped
   assign wa = bus_addr[ADDR_W-1:LSB];
   rd_answer_a: assert property (bus_rd |=> bus_rvalid)
      else $error("read not answered");
   no_stray_rvalid_a: assert property (!bus_rd |=> !bus_rvalid)
      else $error("answer without read");
   ctrl_write_a: assert property (bus_wr && wa == 0 |=> ctrl_wr_pulse && ctrl_r == $past(bus_wdata[7:0]))
      else $error("control write lost");
   flow_hit_a: assert property (bus_wr && wa == 3 |=> flow_valid)
      else $error("flow valid missing");
   flow_only_a: assert property (!(bus_wr && wa == 3) |=> !flow_valid)
      else $error("flow valid stray");
   tap_follow_a: assert property (1'b1 |=> tap_out == $past(bus_wdata[15:8]))
      else $error("tap not following data");
   strm_ready_a: assert property (strm_ready == (bus_rd && wa == 4))
      else $error("stream ready wrong");
   sticky_pulse_a: assert property (bus_rd && wa == 5 |=> sticky_rd_pulse)
      else $error("read hook missing");
   unmapped_zero_a: assert property (bus_rd && wa > 9 |=> bus_rdata == 0)
      else $error("unmapped read not zero");
   drv_hold_a: assert property (!(bus_wr && wa == 2) |=> $stable(drv_out))
      else $error("driven output moved");
   cover property (bus_wr && wa == 9);
   cover property (bus_rd && wa == 5);
   cover property (flow_valid);
endmodule : mrb_register_builder_asserts

bind mrb_register_builder mrb_register_builder_asserts #(.ADDR_W(ADDR_W), .WORD_W(WORD_W))
   mrb_register_builder_asserts_inst (.sys_clk(sys_clk), .arst_n(arst_n),
   .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
   .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .ctrl_r(ctrl_r), .drv_out(drv_out),
   .tap_out(tap_out), .flow_valid(flow_valid), .strm_ready(strm_ready),
   .ctrl_wr_pulse(ctrl_wr_pulse), .sticky_rd_pulse(sticky_rd_pulse));

// File: verification/mrb_strm_src.sv
// Stream source feeding the read-consumed channel: two items, then empty.
// Assumes strm_ready is a one-cycle consume strobe on sys_clk.
`timescale 1ns/10ps
module mrb_strm_src
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Stream
   output logic strm_valid,
   output logic [15:0] strm_payload,
   input wire logic strm_ready
);
   logic [1:0] cnt_r;
   // Item count advances only on a consumed item
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         cnt_r <= 2'h0;
      else if (strm_ready && strm_valid)
         cnt_r <= cnt_r + 2'h1;
   end
   // Empty source shows inverted data, never the stale item
   assign strm_valid = (cnt_r < 2'h2);
   assign strm_payload = strm_valid ? 16'h1000 + 16'(cnt_r) : 16'hefff;
endmodule : mrb_strm_src

// File: verification/testbench.sv
// Self-checking bench for the register builder with a stream source.
// Assumes the map and one-cycle strobe bus of mrb_pkg.
`timescale 1ns/10ps
module testbench;
   import mrb_pkg::*;
   logic sys_clk = 0, arst_n = 0, bus_rd = 0, bus_wr = 0, strm_valid, strm_ready;
   logic [7:0] bus_addr = 0, sticky_in = 0;
   logic [31:0] bus_wdata = 0, bus_rdata, d, seed = 32'he819fde0;
   logic [47:0] wide_rd_in = 0, wide_wr_r, w;
   logic [15:0] strm_payload, flow_payload;
   logic [7:0] ctrl_r, drv_out, drv_rb_out, tap_out;
   logic [11:0] wo_r;
   logic bus_rvalid, flow_valid, ctrl_wr_pulse, sticky_rd_pulse;
   logic [31:0] q[$];
   int error_cnt = 0, checked = 0;
   mrb_register_builder mrb_register_builder_inst (.sys_clk(sys_clk), .arst_n(arst_n),
      .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
      .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .ctrl_r(ctrl_r), .wo_r(wo_r),
      .drv_out(drv_out), .drv_rb_out(drv_rb_out), .wide_wr_r(wide_wr_r), .tap_out(tap_out),
      .flow_valid(flow_valid), .flow_payload(flow_payload), .strm_valid(strm_valid),
      .strm_payload(strm_payload), .strm_ready(strm_ready), .sticky_in(sticky_in),
      .wide_rd_in(wide_rd_in), .ctrl_wr_pulse(ctrl_wr_pulse),
      .sticky_rd_pulse(sticky_rd_pulse));
   mrb_strm_src mrb_strm_src_inst (.sys_clk(sys_clk), .arst_n(arst_n),
      .strm_valid(strm_valid), .strm_payload(strm_payload), .strm_ready(strm_ready));
   // Clock, 100 ns period
   initial
   begin
      forever #50 sys_clk = ~sys_clk;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task chk(input string n, input logic [47:0] g, input logic [47:0] e);
      checked++;
      if (g !== e)
      begin
         $display("MISMATCH %s exp %h got %h", n, e, g);
         error_cnt++;
      end
   endtask : chk
   // One-cycle strobes, as the master side must give
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk) {bus_wr, bus_addr, bus_wdata} <= {1'b1, a, v};
      @(posedge sys_clk) bus_wr <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e);
      q.push_back(e);
      @(posedge sys_clk) {bus_rd, bus_addr} <= {1'b1, a};
      @(posedge sys_clk) bus_rd <= 1'b0;
   endtask : rd
   // Answers are matched in request order
   always @(negedge sys_clk)
      if (bus_rvalid === 1'b1)
         chk("rdata", bus_rdata, q.size() ? q.pop_front() : 32'hx);
   task final_report();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : final_report
   // Hang guard, far beyond the fewer than a hundred cycles of the run
   initial
   begin
      repeat (3000) @(posedge sys_clk);
      error_cnt++;
      final_report();
   end
   initial
   begin
      repeat (16) @(posedge sys_clk);
      arst_n <= 1'b1;
      d = rnd();
      wr(8'h00, d);
      @(negedge sys_clk) chk("ctrl_r", ctrl_r, d[7:0]);
      chk("ctrl_wr_pulse", ctrl_wr_pulse, 1'b1);
      chk("tap_out", tap_out, d[15:8]);
      rd(8'h00, {24'h0, d[7:0]});
      wr(8'h04, d);
      @(negedge sys_clk) chk("wo_r", wo_r, d[15:4]);
      rd(8'h04, 32'h0);
      wr(8'h08, d);
      @(negedge sys_clk) chk("drv_out", drv_out, d[7:0]);
      chk("drv_rb_out", drv_rb_out, d[23:16]);
      rd(8'h08, {8'h0, d[23:16], 16'h0});
      wr(8'h0c, d);
      @(negedge sys_clk) chk("flow_payload", flow_payload, d[15:0]);
      chk("flow_valid", flow_valid, 1'b1);
      @(negedge sys_clk) chk("flow_idle", flow_valid, 1'b0);
      $display("register tests done");
      rd(8'h10, 32'h80001000);
      rd(8'h10, 32'h80001001);
      rd(8'h10, 32'h0000efff);
      @(posedge sys_clk) sticky_in <= 8'h01;
      @(posedge sys_clk) sticky_in <= 8'h80;
      @(posedge sys_clk) sticky_in <= 8'h04;
      rd(8'h14, 32'h85);
      sticky_in <= 8'h00;
      @(negedge sys_clk) chk("sticky_rd_pulse", sticky_rd_pulse, 1'b1);
      rd(8'h14, 32'h04);
      rd(8'h14, 32'h00);
      $display("stream and sticky tests done");
      d = rnd();
      w = {d[15:0], rnd()};
      wide_rd_in <= w;
      rd(8'h18, w[31:0]);
      rd(8'h1c, {16'h0, w[47:32]});
      wr(8'h20, w[31:0]);
      wr(8'h24, {16'h0, w[47:32]});
      @(negedge sys_clk) chk("wide_wr_r", wide_wr_r, w);
      wr(8'h40, rnd());
      rd(8'h40, 32'h0);
      rd(8'h28, 32'h0);
      $display("wide and unmapped tests done");
      @(posedge sys_clk) arst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk) chk("ctrl_rst", ctrl_r, 8'h0);
      chk("drv_rst", drv_out, 8'h0);
      @(posedge sys_clk) arst_n <= 1'b1;
      rd(8'h00, 32'h0);
      repeat (4) @(posedge sys_clk);
      chk("pending", q.size(), 0);
      $display("reset test done");
      final_report();
   end
endmodule : testbench
